// File: logic/drl_ctrl.sv
// Supply-event, serial command and update-strobe control of a two-channel DAC.
// Assumes asynchronous pins, an external serial clock and a supply comparator.
`timescale 1ns/1ps
`include "drl_regs.svh"
module drl_ctrl #(
    parameter int RESET_DELAY_CYC = (`DRL_RESET_DELAY_NS + `DRL_CLK_PERIOD_NS - 1) / `DRL_CLK_PERIOD_NS
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic supply_above_trip,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdi,
    input wire logic output_update_strobe_n,
    input wire logic high_voltage_command_pin,
    output logic sdo,
    output logic sdo_oe,
    output logic interface_ready,
    output logic por_status,
    output logic eeprom_write_start,
    output logic [1:0][`DRL_DAC_W-1:0] dac_value,
    output logic [`DRL_CFG_W-1:0] reference_select_bits,
    output logic [`DRL_CFG_W-1:0] powerdown_select_bits,
    output logic [`DRL_GAIN_W-1:0] gain_select_bit,
    output logic [`DRL_USER_BITS-1:0] user_config_bits
);
    localparam int DLY_W = $clog2(RESET_DELAY_CYC + 1);

    // ****************************************
    // pin synchronisers
    // ****************************************
    drl_sync_if #(.W(`DRL_PIN_N)) pins ();
    logic [`DRL_PIN_N-1:0] s;

    assign pins.raw = {high_voltage_command_pin, output_update_strobe_n, sdi, sck, cs_n, supply_above_trip};
    assign s = pins.sync;

    drl_sync #(.W(`DRL_PIN_N)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .sif(pins)
    );

    // ****************************************
    // state
    // ****************************************
    drl_pkg::drl_state_t state_ff, nxt_state;
    logic [`DRL_PIN_N-1:0] d_ff, nxt_d;
    logic [DLY_W-1:0] dly_ff, nxt_dly;
    logic [4:0] cnt_ff, nxt_cnt;
    logic [`DRL_FRAME_W-1:0] shin_ff, nxt_shin;
    logic [`DRL_WORD_W-1:0] shout_ff, nxt_shout;
    logic sdo_ff, nxt_sdo;
    logic sdo_oe_ff, nxt_sdo_oe;
    logic rdy_ff, nxt_rdy;
    logic por_ff, nxt_por;
    logic nvw_ff, nxt_nvw;
    logic [1:0][`DRL_DAC_W-1:0] stg_dac_ff, nxt_stg_dac;
    logic [1:0][`DRL_DAC_W-1:0] out_dac_ff, nxt_out_dac;
    logic [`DRL_CFG_W-1:0] stg_vref_ff, nxt_stg_vref, out_vref_ff, nxt_out_vref;
    logic [`DRL_CFG_W-1:0] stg_pd_ff, nxt_stg_pd, out_pd_ff, nxt_out_pd;
    logic [`DRL_GAIN_W-1:0] stg_gain_ff, nxt_stg_gain, out_gain_ff, nxt_out_gain;
    logic [`DRL_USER_BITS-1:0] ucfg_ff, nxt_ucfg;
    // stored words, sixteen bits each
    logic [`DRL_WORD_W-1:0] nv_ff [`DRL_NV_WORDS];
    logic [`DRL_WORD_W-1:0] nxt_nv [`DRL_NV_WORDS];

    // serial clock is only sampled, never produced
    logic sup_rise, sup_fall, cs_rise, sck_rise, sck_fall;
    assign sup_rise = s[`DRL_PIN_SUP] & ~d_ff[`DRL_PIN_SUP];
    assign sup_fall = ~s[`DRL_PIN_SUP] & d_ff[`DRL_PIN_SUP];
    assign cs_rise = s[`DRL_PIN_CS] & ~d_ff[`DRL_PIN_CS];
    assign sck_rise = s[`DRL_PIN_SCK] & ~d_ff[`DRL_PIN_SCK];
    assign sck_fall = ~s[`DRL_PIN_SCK] & d_ff[`DRL_PIN_SCK];

    function automatic logic [`DRL_WORD_W-1:0] rd_word(input logic [4:0] a);
        logic [`DRL_WORD_W-1:0] w;
        w = `DRL_ZERO_WORD;
        if (a[`DRL_NV_BIT])
            w = nv_ff[a[3:0]];
        else
        begin
            case (a)
                `DRL_A_DAC0: w[`DRL_DAC_W-1:0] = stg_dac_ff[0];
                `DRL_A_DAC1: w[`DRL_DAC_W-1:0] = stg_dac_ff[1];
                `DRL_A_VREF: w[`DRL_CFG_W-1:0] = stg_vref_ff;
                `DRL_A_PD: w[`DRL_CFG_W-1:0] = stg_pd_ff;
                `DRL_A_GAIN:
                begin
                    w[`DRL_GAIN_LSB +: `DRL_GAIN_W] = stg_gain_ff;
                    w[`DRL_POR_BIT] = por_ff;
                end
                default: w = `DRL_RSVD_WORD;
            endcase
        end
        return w;
    endfunction

    // ****************************************
    // next-state logic
    // ****************************************
    logic [7:0] cbyte;
    logic [7:0] fbyte;
    logic [`DRL_WORD_W-1:0] fdata;
    logic [4:0] fa;
    drl_pkg::drl_cmd_t fcmd;

    always_comb
    begin
        cbyte = {shin_ff[6:0], s[`DRL_PIN_SDI]};
        fbyte = (cnt_ff == `DRL_CNT_FRAME) ? shin_ff[23:16] : shin_ff[7:0];
        fdata = shin_ff[15:0];
        fa = fbyte[7:3];
        fcmd = drl_pkg::drl_cmd_t'(fbyte[2:1]);
        nxt_state = state_ff;
        nxt_d = s;
        nxt_dly = dly_ff;
        nxt_cnt = cnt_ff;
        nxt_shin = shin_ff;
        nxt_shout = shout_ff;
        nxt_sdo = sdo_ff;
        nxt_sdo_oe = 1'b0;
        nxt_por = por_ff;
        nxt_nvw = 1'b0;
        nxt_stg_dac = stg_dac_ff;
        nxt_stg_vref = stg_vref_ff;
        nxt_stg_pd = stg_pd_ff;
        nxt_stg_gain = stg_gain_ff;
        nxt_out_dac = out_dac_ff;
        nxt_out_vref = out_vref_ff;
        nxt_out_pd = out_pd_ff;
        nxt_out_gain = out_gain_ff;
        nxt_ucfg = ucfg_ff;
        nxt_nv = nv_ff;
        // level-sensitive transfer keeps both channels moving together
        if (!s[`DRL_PIN_LAT] && state_ff != drl_pkg::DRL_ST_OFF)
        begin
            nxt_out_dac = stg_dac_ff;
            nxt_out_vref = stg_vref_ff;
            nxt_out_pd = stg_pd_ff;
            nxt_out_gain = stg_gain_ff;
        end
        case (state_ff)
            drl_pkg::DRL_ST_OFF:
            begin
                if (sup_rise)
                begin
                    nxt_state = drl_pkg::DRL_ST_DELAY;
                    nxt_dly = '0;
                    nxt_por = 1'b1;
                    nxt_stg_dac[0] = nv_ff[`DRL_A_DAC0 % `DRL_NV_WORDS][`DRL_DAC_W-1:0];
                    nxt_stg_dac[1] = nv_ff[`DRL_A_DAC1 % `DRL_NV_WORDS][`DRL_DAC_W-1:0];
                    nxt_stg_vref = nv_ff[`DRL_A_VREF % `DRL_NV_WORDS][`DRL_CFG_W-1:0];
                    nxt_stg_pd = nv_ff[`DRL_A_PD % `DRL_NV_WORDS][`DRL_CFG_W-1:0];
                    nxt_stg_gain = nv_ff[`DRL_A_GAIN % `DRL_NV_WORDS][`DRL_GAIN_LSB +: `DRL_GAIN_W];
                    nxt_out_dac = nxt_stg_dac;
                    nxt_out_vref = nxt_stg_vref;
                    nxt_out_pd = nxt_stg_pd;
                    nxt_out_gain = nxt_stg_gain;
                end
            end
            drl_pkg::DRL_ST_DELAY:
            begin
                if (dly_ff == DLY_W'(RESET_DELAY_CYC - 1))
                    nxt_state = drl_pkg::DRL_ST_READY;
                else
                    nxt_dly = DLY_W'(dly_ff + 1'b1);
            end
            drl_pkg::DRL_ST_READY:
            begin
                // operation continues down to the trip level
                if (s[`DRL_PIN_CS])
                begin
                    nxt_cnt = '0;
                    if (cs_rise && cnt_ff == `DRL_CNT_FRAME && fcmd == drl_pkg::DRL_CMD_WRITE)
                    begin
                        if (fa[`DRL_NV_BIT])
                        begin
                            nxt_nv[fa[3:0]] = fdata;
                            nxt_nvw = 1'b1;
                        end
                        else
                        begin
                            case (fa)
                                `DRL_A_DAC0: nxt_stg_dac[0] = fdata[`DRL_DAC_W-1:0];
                                `DRL_A_DAC1: nxt_stg_dac[1] = fdata[`DRL_DAC_W-1:0];
                                `DRL_A_VREF: nxt_stg_vref = fdata[`DRL_CFG_W-1:0];
                                `DRL_A_PD: nxt_stg_pd = fdata[`DRL_CFG_W-1:0];
                                `DRL_A_GAIN:
                                begin
                                    nxt_stg_gain = fdata[`DRL_GAIN_LSB +: `DRL_GAIN_W];
                                    if (!fdata[`DRL_POR_BIT])
                                        nxt_por = 1'b0;
                                end
                                default: nxt_por = por_ff;
                            endcase
                        end
                    end
                    // user bits have no address, only high-voltage commands
                    if (cs_rise && cnt_ff == `DRL_CNT_CMD && s[`DRL_PIN_HV] && fa < 5'(`DRL_USER_BITS)
                        && (fcmd == drl_pkg::DRL_CMD_HV_EN || fcmd == drl_pkg::DRL_CMD_HV_DIS))
                        nxt_ucfg[fa[2:0]] = (fcmd == drl_pkg::DRL_CMD_HV_EN);
                end
                else
                begin
                    nxt_sdo_oe = 1'b1;
                    if (sck_rise && cnt_ff != `DRL_CNT_FRAME)
                    begin
                        nxt_shin = {shin_ff[`DRL_FRAME_W-2:0], s[`DRL_PIN_SDI]};
                        nxt_cnt = 5'(cnt_ff + 5'h01);
                        if (nxt_cnt == `DRL_CNT_CMD && cbyte[2:1] == drl_pkg::DRL_CMD_READ)
                            nxt_shout = rd_word(cbyte[7:3]);
                    end
                    if (sck_fall)
                    begin
                        nxt_sdo = shout_ff[`DRL_WORD_W-1];
                        nxt_shout = {shout_ff[`DRL_WORD_W-2:0], 1'b0};
                    end
                end
            end
            default: nxt_state = drl_pkg::DRL_ST_OFF;
        endcase
        if (sup_fall && state_ff != drl_pkg::DRL_ST_OFF)
        begin
            nxt_state = drl_pkg::DRL_ST_OFF;
            nxt_sdo_oe = 1'b0;
            nxt_nv = nv_ff;
            nxt_nvw = 1'b0;
            nxt_stg_pd = `DRL_PD_OFF;
            nxt_out_pd = `DRL_PD_OFF;
            nxt_stg_dac = '0;
            nxt_out_dac = '0;
            nxt_stg_vref = '0;
            nxt_out_vref = '0;
            nxt_stg_gain = '0;
            nxt_out_gain = '0;
        end
        // half-shifted frame is thrown away on any supply crossing
        if (sup_rise || sup_fall)
        begin
            nxt_cnt = '0;
            nxt_shin = '0;
        end
        nxt_rdy = (nxt_state == drl_pkg::DRL_ST_READY);
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_ff <= drl_pkg::DRL_ST_OFF;
            d_ff <= '0;
            dly_ff <= '0;
            cnt_ff <= '0;
            shin_ff <= '0;
            shout_ff <= '0;
            sdo_ff <= 1'b0;
            sdo_oe_ff <= 1'b0;
            rdy_ff <= 1'b0;
            por_ff <= 1'b0;
            nvw_ff <= 1'b0;
            stg_dac_ff <= '0;
            out_dac_ff <= '0;
            stg_vref_ff <= '0;
            out_vref_ff <= '0;
            stg_pd_ff <= `DRL_PD_OFF;
            out_pd_ff <= `DRL_PD_OFF;
            stg_gain_ff <= '0;
            out_gain_ff <= '0;
            ucfg_ff <= '0;
            for (int i = 0; i < `DRL_NV_WORDS; i++)
                nv_ff[i] <= (i < 2) ? `DRL_NV_DAC_INIT : `DRL_ZERO_WORD;
        end
        else if (ce)
        begin
            state_ff <= nxt_state;
            d_ff <= nxt_d;
            dly_ff <= nxt_dly;
            cnt_ff <= nxt_cnt;
            shin_ff <= nxt_shin;
            shout_ff <= nxt_shout;
            sdo_ff <= nxt_sdo;
            sdo_oe_ff <= nxt_sdo_oe;
            rdy_ff <= nxt_rdy;
            por_ff <= nxt_por;
            nvw_ff <= nxt_nvw;
            stg_dac_ff <= nxt_stg_dac;
            out_dac_ff <= nxt_out_dac;
            stg_vref_ff <= nxt_stg_vref;
            out_vref_ff <= nxt_out_vref;
            stg_pd_ff <= nxt_stg_pd;
            out_pd_ff <= nxt_out_pd;
            stg_gain_ff <= nxt_stg_gain;
            out_gain_ff <= nxt_out_gain;
            ucfg_ff <= nxt_ucfg;
            nv_ff <= nxt_nv;
        end
    end

    assign sdo = sdo_ff;
    assign sdo_oe = sdo_oe_ff;
    assign interface_ready = rdy_ff;
    assign por_status = por_ff;
    assign eeprom_write_start = nvw_ff;
    assign dac_value = out_dac_ff;
    assign reference_select_bits = out_vref_ff;
    assign powerdown_select_bits = out_pd_ff;
    assign gain_select_bit = out_gain_ff;
    assign user_config_bits = ucfg_ff;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb_sys @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence bor_seen;
        ce && sup_fall && state_ff != drl_pkg::DRL_ST_OFF;
    endsequence

    a_bor_powerdown: assert property (bor_seen |=> out_pd_ff == `DRL_PD_OFF)
        else $error("power-down not forced on brown-out");
    a_bor_dac_zero: assert property (bor_seen |=> out_dac_ff == '0 && stg_dac_ff == '0)
        else $error("dac value not cleared on brown-out");
    a_bor_cfg_zero: assert property (bor_seen |=> out_vref_ff == '0 && out_gain_ff == '0)
        else $error("reference or gain not cleared on brown-out");
    a_por_flag_set: assert property (ce && sup_rise && state_ff == drl_pkg::DRL_ST_OFF |=> por_ff)
        else $error("power-on flag not set");
    a_por_recall: assert property (ce && sup_rise && state_ff == drl_pkg::DRL_ST_OFF
        |=> stg_dac_ff[0] == $past(nv_ff[0][`DRL_DAC_W-1:0]))
        else $error("stored dac value not recalled");
    a_quiet_not_ready: assert property (state_ff != drl_pkg::DRL_ST_READY |-> cnt_ff == '0)
        else $error("serial bits taken outside ready state");
    a_latch_moves: assert property (ce && !s[`DRL_PIN_LAT] && state_ff == drl_pkg::DRL_ST_READY
        && !sup_fall |=> out_dac_ff == $past(stg_dac_ff))
        else $error("update strobe did not move staged value");
    a_user_hv_only: assert property (ucfg_ff != $past(ucfg_ff) |-> $past(s[`DRL_PIN_HV]))
        else $error("user bits changed without high voltage");
    a_cross_abort: assert property (ce && (sup_rise || sup_fall) |=> cnt_ff == '0)
        else $error("frame survived supply crossing");
    a_nv_at_cs: assert property (nvw_ff |-> $past(cs_rise) && $past(state_ff) == drl_pkg::DRL_ST_READY)
        else $error("eeprom write started outside chip select release");
endmodule // drl_ctrl

// File: logic/drl_regs.svh
// Constants for the supply-event and update control block of the serial DAC.
// Assumes the including file uses the drl_pkg types alongside these names.
// Function
// - active update strobe moves staged DAC values to outputs together
// - reference, power-down and gain bits update with the strobe too
// - user configuration bits change only while high-voltage pin is high
// - serial commands accepted only while chip select is active
// - supply rising through trip copies stored DAC value to volatile
// - same power-on event copies stored configuration to volatile bits
// - power-on event sets the power-on status flag to one
// - reset delay after power-on; all serial commands ignored meanwhile
// - brown-out disables serial interface and blocks EEPROM writes
// - brown-out forces power-down selection to binary 1111
// - brown-out clears volatile DAC register to 000h
// - brown-out clears reference select and gain bits to zero
// - every user memory word is sixteen bits wide
// - five user bits sit outside the map, reached by high-voltage commands
// - serial clock comes only from the host; none generated here
// - one trip level: rising is power-on, falling is brown-out
// - between trip point and 2.7V reads and writes still work
// - EEPROM write starts only when chip select returns inactive
// - writing a stored location leaves its volatile register unchanged
`ifndef DRL_REGS_SVH
`define DRL_REGS_SVH

`define DRL_DAC_W 12
`define DRL_WORD_W 16
`define DRL_CFG_W 4
`define DRL_GAIN_W 2
`define DRL_USER_BITS 5
`define DRL_NV_WORDS 16
`define DRL_FRAME_W 24
`define DRL_CNT_CMD 5'h08
`define DRL_CNT_FRAME 5'h18
`define DRL_PIN_N 6
`define DRL_PIN_SUP 0
`define DRL_PIN_CS 1
`define DRL_PIN_SCK 2
`define DRL_PIN_SDI 3
`define DRL_PIN_LAT 4
`define DRL_PIN_HV 5
`define DRL_A_DAC0 5'h00
`define DRL_A_DAC1 5'h01
`define DRL_A_VREF 5'h08
`define DRL_A_PD 5'h09
`define DRL_A_GAIN 5'h0A
`define DRL_NV_BIT 4
`define DRL_POR_BIT 7
`define DRL_GAIN_LSB 8
`define DRL_PD_OFF 4'hF
`define DRL_RSVD_WORD 16'hFFFF
`define DRL_NV_DAC_INIT 16'h07FF
`define DRL_ZERO_WORD 16'h0000
`define DRL_CLK_PERIOD_NS 10
`define DRL_RESET_DELAY_NS 2000

`endif

// File: logic/drl_pkg.sv
// Types shared by the supply-event and update control block.
// Assumes drl_regs.svh supplies the numeric constants.
package drl_pkg;
    // gray along off -> delay -> ready
    typedef enum logic [1:0] {
        DRL_ST_OFF = 2'h0,
        DRL_ST_DELAY = 2'h1,
        DRL_ST_READY = 2'h3
    } drl_state_t;

    typedef enum logic [1:0] {
        DRL_CMD_WRITE = 2'h0,
        DRL_CMD_HV_EN = 2'h1,
        DRL_CMD_HV_DIS = 2'h2,
        DRL_CMD_READ = 2'h3
    } drl_cmd_t;
endpackage

// File: logic/drl_sync_if.sv
// Carrier for pin levels and their synchronised copies.
// Assumes one clock domain, clk_sys, on the synchronised side.
`timescale 1ns/1ps
interface drl_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport sync_side (input raw, output sync);
    modport user (output raw, input sync);
endinterface

// File: logic/drl_sync.sv
// Two-flop synchroniser for a group of pins.
// Assumes raw inputs are asynchronous to clk_sys.
`timescale 1ns/1ps
module drl_sync #(parameter int W = 1)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    drl_sync_if.sync_side sif
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] hold_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_hold;

    always_comb
    begin
        nxt_meta = sif.raw;
        nxt_hold = meta_ff;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            meta_ff <= '0;
            hold_ff <= '0;
        end
        else if (ce)
        begin
            meta_ff <= nxt_meta;
            hold_ff <= nxt_hold;
        end
    end

    assign sif.sync = hold_ff;
endmodule // drl_sync

// File: tb/drl_host.sv
// Serial host model for the supply-event and update control block.
// Assumes the bench calls frame() and waits for it to return.
`timescale 1ns/1ps
module drl_host
(
    output logic cs_n,
    output logic sck,
    output logic sdi,
    input wire logic sdo
);
    localparam time HALF = 80ns;

    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end

    // n bits msb first from w[23]; sel low keeps chip select off
    task automatic frame(input logic [23:0] w, input int n, input logic sel, output logic [15:0] rd);
        rd = 16'h0000;
        // release of a previous frame must stand long enough to commit it
        #HALF;
        cs_n = ~sel;
        #HALF;
        for (int i = 0; i < n; i++)
        begin
            sdi = w[23-i];
            #HALF;
            sck = 1'b1;
            rd = {rd[14:0], sdo};
            #HALF;
            sck = 1'b0;
        end
        #HALF;
        cs_n = 1'b1;
        // released line must not keep showing the last bit
        sdi = ~sdi;
    endtask
endmodule // drl_host

// File: tb/testbench.sv
// Self-checking bench for the supply-event and update control block.
// Assumes drl_ctrl with a short reset delay and the drl_host serial model.
`timescale 1ns/1ps
`include "drl_regs.svh"
`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end
module testbench;
    typedef struct packed {logic [4:0] addr; logic [15:0] data; logic [2:0] sel; logic [15:0] exp;} drl_row_t;
    localparam int DLY = 4;
    localparam int LIMIT = 20000;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic supply_above_trip = 1'b1;
    logic output_update_strobe_n = 1'b0;
    logic high_voltage_command_pin = 1'b0;
    logic cs_n, sck, sdi, sdo, sdo_oe, interface_ready, por_status, eeprom_write_start;
    logic [1:0][`DRL_DAC_W-1:0] dac_value;
    logic [`DRL_CFG_W-1:0] reference_select_bits;
    logic [`DRL_CFG_W-1:0] powerdown_select_bits;
    logic [`DRL_GAIN_W-1:0] gain_select_bit;
    logic [`DRL_USER_BITS-1:0] user_config_bits;
    logic [15:0] rd;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    int ee_cnt = 0;
    int n;
    // sel: 0/1 dac, 2 vref, 3 power-down, 4 gain, 5 por flag, 6 read back
    drl_row_t rows [8] = '{'{5'h00, 16'h0123, 3'h0, 16'h0123}, '{5'h01, 16'hFABC, 3'h1, 16'h0ABC},
        '{5'h08, 16'h0005, 3'h2, 16'h0005}, '{5'h09, 16'h000A, 3'h3, 16'h000A},
        '{5'h0A, 16'h0200, 3'h4, 16'h0002}, '{5'h0A, 16'h0300, 3'h5, 16'h0000},
        '{5'h03, 16'h0000, 3'h6, 16'hFFFF}, '{5'h08, 16'h0000, 3'h6, 16'h0005}};

    drl_ctrl #(.RESET_DELAY_CYC(DLY)) uut (.clk_sys, .rst, .ce, .supply_above_trip, .cs_n, .sck, .sdi,
        .output_update_strobe_n, .high_voltage_command_pin, .sdo, .sdo_oe, .interface_ready, .por_status,
        .eeprom_write_start, .dac_value, .reference_select_bits, .powerdown_select_bits, .gain_select_bit,
        .user_config_bits);
    drl_host host (.cs_n, .sck, .sdi, .sdo);

    always #5 clk_sys = ~clk_sys;

    // sampled off the launch edge so a one-cycle pulse is counted once
    always @(negedge clk_sys)
    begin
        cycles++;
        if (eeprom_write_start === 1'b1)
            ee_cnt++;
        if (cycles == LIMIT)
        begin
            err_total++;
            results();
        end
    end

    function automatic logic [15:0] port_val(input logic [2:0] sel);
        case (sel)
            3'h0: return {4'h0, dac_value[0]};
            3'h1: return {4'h0, dac_value[1]};
            3'h2: return {12'h000, reference_select_bits};
            3'h3: return {12'h000, powerdown_select_bits};
            3'h4: return {14'h0000, gain_select_bit};
            default: return {15'h0000, por_status};
        endcase
    endfunction

    task automatic settle();
        repeat (12) @(negedge clk_sys);
    endtask

    task automatic send(input logic [7:0] cmd, input logic [15:0] d);
        host.frame({cmd, d}, 24, 1'b1, rd);
    endtask

    task automatic hv_cmd(input logic [7:0] cmd);
        host.frame({cmd, 16'h0000}, 8, 1'b1, rd);
        settle();
    endtask

    // bounded wait; n counts cycles with the power-on flag up
    task automatic wait_ready();
        n = 0;
        for (int k = 0; k < 60 && interface_ready !== 1'b1; k++)
        begin
            @(negedge clk_sys);
            if (por_status === 1'b1)
                n++;
        end
    endtask

    task automatic results();
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        // ************************************************
        // reset and power-on
        // ************************************************
        repeat (6) @(negedge clk_sys);
        `CHK(powerdown_select_bits, 4'hF) // [RESET]
        rst = 1'b0;
        wait_ready();
        `CHK(interface_ready, 1'b1)
        `CHK(n >= DLY && n <= DLY + 3, 1'b1)
        `CHK(por_status, 1'b1)
        `CHK(dac_value[1], 12'h7FF)
        `CHK(powerdown_select_bits, 4'h0)
        foreach (rows[i])
        begin
            if (rows[i].sel == 3'h6)
                send({rows[i].addr, 3'b110}, 16'h0000);
            else
                send({rows[i].addr, 3'b000}, rows[i].data);
            settle();
            `CHK((rows[i].sel == 3'h6) ? rd : port_val(rows[i].sel), rows[i].exp)
        end
        // ************************************************
        // strobe, chip select, high-voltage, stored words
        // ************************************************
        output_update_strobe_n = 1'b1;
        send(8'h00, 16'h0456);
        send(8'h40, 16'h0009);
        settle();
        `CHK(dac_value[0], 12'h123)
        `CHK(reference_select_bits, 4'h5)
        output_update_strobe_n = 1'b0;
        settle();
        `CHK(dac_value[0], 12'h456)
        `CHK(reference_select_bits, 4'h9)
        host.frame(24'h000AAA, 24, 1'b0, rd);
        settle();
        `CHK(dac_value[0], 12'h456)
        hv_cmd(8'h12);
        `CHK(user_config_bits, 5'h00)
        high_voltage_command_pin = 1'b1;
        hv_cmd(8'h12);
        `CHK(user_config_bits, 5'h04)
        hv_cmd(8'h2A);
        `CHK(user_config_bits, 5'h04)
        hv_cmd(8'h14);
        `CHK(user_config_bits, 5'h00)
        high_voltage_command_pin = 1'b0;
        send(8'h80, 16'h0321);
        `CHK(ee_cnt, 0)
        settle();
        `CHK(ee_cnt, 1)
        send(8'hC0, 16'h0002);
        settle();
        `CHK(dac_value[0], 12'h456)
        `CHK(reference_select_bits, 4'h9)
        // ************************************************
        // brown-out, recovery, abort
        // ************************************************
        supply_above_trip = 1'b0;
        settle();
        `CHK(interface_ready, 1'b0)
        `CHK(powerdown_select_bits, 4'hF)
        `CHK(dac_value, 24'h000000)
        `CHK({reference_select_bits, gain_select_bit}, 6'h00)
        fork
            send(8'h88, 16'h0555);
            begin
                #400;
                `CHK(sdo_oe, 1'b0)
            end
        join
        settle();
        `CHK(ee_cnt, 2)
        supply_above_trip = 1'b1;
        wait_ready();
        `CHK(por_status, 1'b1)
        `CHK(dac_value[0], 12'h321)
        `CHK(reference_select_bits, 4'h2)
        `CHK(dac_value[1], 12'h7FF)
        fork
            send(8'h00, 16'h0BBB);
            begin
                #400;
                `CHK(sdo_oe, 1'b1)
                // one-cycle dip between two serial clock rises: only the abort can lose the frame
                #655;
                @(negedge clk_sys) supply_above_trip = 1'b0;
                @(negedge clk_sys) supply_above_trip = 1'b1;
            end
        join
        settle();
        `CHK(dac_value[0], 12'h321)
        `CHK(interface_ready, 1'b1)
        // a supply dip hidden by a frozen clock enable must not be seen
        ce = 1'b0;
        supply_above_trip = 1'b0;
        settle();
        `CHK(interface_ready, 1'b1)
        supply_above_trip = 1'b1;
        settle();
        ce = 1'b1;
        settle();
        `CHK(interface_ready, 1'b1)
        `CHK(dac_value[0], 12'h321)
        results();
    end
endmodule // testbench
